// file: include/crsw_pkg.sv
package crsw_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [3:0] IDX_INDIRECT_DATA_WINDOW = 4'h0;
  localparam logic [3:0] IDX_TIMER_COUNT          = 4'h1;
  localparam logic [3:0] IDX_PROGRAM_COUNTER_LOW  = 4'h2;
  localparam logic [3:0] IDX_CORE_FLAGS           = 4'h3;
  localparam logic [3:0] IDX_INDIRECT_POINTER     = 4'h4;
  localparam logic [3:0] IDX_PIN_GROUP_A          = 4'h5;
  localparam logic [3:0] IDX_PIN_DIRECTION_A      = 4'h8;
  localparam logic [3:0] IDX_TIMER_PRESCALE_CFG   = 4'hB;
  localparam logic [3:0] IDX_CORE_CONTROL         = 4'hC;
  localparam logic [3:0] IDX_POWER_STATE          = 4'hD;
  localparam int         ADDR_LSB                 = 2;
  localparam int         ADDR_IDX_W               = 4;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int         FLAG_TIMEOUT_BIT      = 4;
  localparam int         FLAG_POWERDOWN_BIT    = 3;
  localparam int         FLAG_PAGE_LSB         = 5;
  localparam int         CONTROL_WDT_EN_BIT    = 0;
  localparam int         STATE_SLEEP_BIT       = 0;
  localparam logic [7:0] PCL_RESET             = 8'hFF;
  localparam logic [7:0] DIRECTION_RESET       = 8'hFF;
  localparam logic [5:0] PRESCALE_CFG_RESET    = 6'h3F;
  localparam logic [2:0] PAGE_RESET            = 3'h0;
  localparam logic [2:0] ALU_FLAGS_RESET       = 3'h0;
  localparam logic [7:0] CONTROL_RESET         = 8'h00;
  localparam logic [2:0] POINTER_TOP_SMALL     = 3'h7;
  localparam logic [7:0] GROUP_A_MASK          = 8'h0F;
  localparam logic [11:0] POWERDOWN_OPCODE     = 12'h003;

  // ------------------------------------------------------------
  // data memory and bus answers
  // ------------------------------------------------------------
  localparam int         FILE_ADDR_W           = 7;
  localparam int         DATA_MEM_DEPTH        = 128;
  localparam logic [6:0] FILE_PIN_GROUP_C      = 7'h07;
  localparam logic [6:0] FILE_FIRST_GPR        = 7'h08;
  localparam logic [1:0] RESP_OKAY             = 2'h0;
  localparam logic [1:0] RESP_SLVERR           = 2'h2;

  typedef enum logic {PWR_RUN, PWR_SLEEP} crsw_power_e;

  typedef struct packed {
    logic [2:0][7:0] group;
  } crsw_pins_s;

endpackage

// file: design/crsw_core_regs.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module crsw_core_regs
  import crsw_pkg::*;
#(
  parameter bit SMALL_MEMORY    = 1'b0,
  parameter bit HAS_PIN_GROUP_C = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr_word,
  input  wire logic        timer_tick,
  input  wire logic        master_clear_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire crsw_pins_s  pin_in,
  output crsw_pins_s       pin_out,
  output crsw_pins_s       pin_oe,
  output logic [7:0]       program_counter_low,
  output logic             osc_enable,
  output logic             watchdog_clear,
  output logic             core_reset,
  output logic             powered_down
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] pointer_view(input logic [7:0] raw);
    if (SMALL_MEMORY) begin
      pointer_view = {POINTER_TOP_SMALL, raw[4:0]};
    end else begin
      pointer_view = {1'b1, raw[6:0]};
    end
  endfunction

  function automatic logic [6:0] file_target(input logic [3:0] idx, input logic [7:0] ptr);
    if (idx == IDX_INDIRECT_DATA_WINDOW) begin
      file_target = SMALL_MEMORY ? {2'h0, ptr[4:0]} : ptr[6:0];
    end else begin
      file_target = {3'h0, idx};
    end
  endfunction

  function automatic logic idx_mapped(input logic [31:0] addr);
    idx_mapped = (addr[31:ADDR_LSB+ADDR_IDX_W] == '0)
      && (addr[ADDR_LSB+ADDR_IDX_W-1:ADDR_LSB] <= IDX_POWER_STATE);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  crsw_power_e power_state;
  logic [7:0]  timer_count;
  logic [7:0]  indirect_pointer;
  logic [2:0]  page_select;
  logic        timeout_flag;
  logic        powerdown_flag;
  logic [2:0]  alu_flags;
  logic [5:0]  timer_prescale_config;
  logic [7:0]  core_control;
  logic [7:0]  data_mem [0:DATA_MEM_DEPTH-1];

  logic        aw_held;
  logic        w_held;
  logic [31:0] awaddr_q;
  logic [7:0]  wdata_q;
  logic        wstrb_q;

  logic        wdt_enabled;
  logic        wdt_reset_req;
  logic        dev_reset_req;
  logic        sleep_exec;
  logic        run_exec;
  logic        wr_cycle;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [6:0]  wr_file;
  logic [3:0]  rd_idx;
  logic [6:0]  rd_file;
  logic [7:0]  file_rd_data;
  logic [7:0]  next_rdata;

  assign wdt_enabled   = core_control[CONTROL_WDT_EN_BIT];
  assign wdt_reset_req = watchdog_timeout && wdt_enabled;
  assign dev_reset_req = !master_clear_pin_n || wdt_reset_req;
  assign run_exec      = instr_valid && (power_state == PWR_RUN) && !dev_reset_req;
  assign sleep_exec    = run_exec && (instr_word == POWERDOWN_OPCODE);
  assign wr_cycle      = aw_held && w_held && !bvalid;
  assign wr_idx        = awaddr_q[ADDR_LSB+ADDR_IDX_W-1:ADDR_LSB];
  assign wr_en         = wr_cycle && wstrb_q && idx_mapped(awaddr_q)
                         && (power_state == PWR_RUN) && !dev_reset_req;
  assign wr_file       = file_target(wr_idx, pointer_view(indirect_pointer));
  assign rd_idx        = araddr[ADDR_LSB+ADDR_IDX_W-1:ADDR_LSB];
  assign rd_file       = file_target(rd_idx, pointer_view(indirect_pointer));

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_state <= PWR_RUN;
      osc_enable  <= 1'b1;
    end else begin
      unique case (power_state)
        PWR_RUN: begin
          if (sleep_exec) begin
            power_state <= PWR_SLEEP;
            osc_enable  <= 1'b0;
          end
        end
        PWR_SLEEP: begin
          if (dev_reset_req) begin
            power_state <= PWR_RUN;
            osc_enable  <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      powered_down   <= 1'b0;
      watchdog_clear <= 1'b0;
      core_reset     <= 1'b1;
    end else begin
      powered_down   <= (power_state == PWR_SLEEP) ? !dev_reset_req : sleep_exec;
      watchdog_clear <= (sleep_exec && wdt_enabled)
                        || ((power_state == PWR_SLEEP) && dev_reset_req);
      core_reset     <= dev_reset_req;
    end
  end

  // ------------------------------------------------------------
  // core flags
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (wdt_reset_req) begin
      timeout_flag   <= 1'b0;
    end else if (sleep_exec) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      page_select <= PAGE_RESET;
      alu_flags   <= ALU_FLAGS_RESET;
    end else if (dev_reset_req) begin
      page_select <= PAGE_RESET;
    end else if (wr_en && wr_file == {3'h0, IDX_CORE_FLAGS}) begin
      page_select <= wdata_q[7:FLAG_PAGE_LSB];
      alu_flags   <= wdata_q[2:0];
    end
  end

  // ------------------------------------------------------------
  // program counter low, timer, pointer, configuration
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset_req) begin
      program_counter_low <= PCL_RESET;
    end else if (wr_en && wr_file == {3'h0, IDX_PROGRAM_COUNTER_LOW}) begin
      program_counter_low <= wdata_q;
    end else if (run_exec) begin
      program_counter_low <= program_counter_low + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en && wr_file == {3'h0, IDX_TIMER_COUNT}) begin
      timer_count <= wdata_q;
    end else if (timer_tick && power_state == PWR_RUN) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en && wr_file == {3'h0, IDX_INDIRECT_POINTER}) begin
      indirect_pointer <= wdata_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || dev_reset_req) begin
      timer_prescale_config <= PRESCALE_CFG_RESET;
    end else if (wr_en && wr_idx == IDX_TIMER_PRESCALE_CFG) begin
      timer_prescale_config <= wdata_q[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_control <= CONTROL_RESET;
    end else if (wr_en && wr_idx == IDX_CORE_CONTROL) begin
      core_control <= {7'h00, wdata_q[CONTROL_WDT_EN_BIT]};
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en && wr_idx < IDX_PIN_DIRECTION_A && (wr_file >= FILE_FIRST_GPR
        || (wr_file == FILE_PIN_GROUP_C && !HAS_PIN_GROUP_C))) begin
      data_mem[wr_file] <= wdata_q;
    end
  end

  // ------------------------------------------------------------
  // pin groups
  // ------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : gen_pins
    localparam logic [7:0] MASK    = (g == 0) ? GROUP_A_MASK : 8'hFF;
    localparam bit         PRESENT = (g != 2) || HAS_PIN_GROUP_C;
    always_ff @(posedge aclk) begin
      if (!aresetn || dev_reset_req) begin
        pin_oe.group[g] <= ~DIRECTION_RESET;
      end else if (PRESENT && wr_en && wr_idx == IDX_PIN_DIRECTION_A + 4'(g)) begin
        pin_oe.group[g] <= ~wdata_q & MASK;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out.group[g] <= 8'h00;
      end else if (PRESENT && wr_en
                   && wr_file == {3'h0, IDX_PIN_GROUP_A + 4'(g)}) begin
        pin_out.group[g] <= wdata_q & MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    file_rd_data = 8'h00;
    if (rd_file >= FILE_FIRST_GPR) begin
      file_rd_data = data_mem[rd_file];
    end else begin
      unique case (rd_file[2:0])
        3'h0: file_rd_data = 8'h00;
        3'h1: file_rd_data = timer_count;
        3'h2: file_rd_data = program_counter_low;
        3'h3: file_rd_data = {page_select, timeout_flag, powerdown_flag, alu_flags};
        3'h4: file_rd_data = pointer_view(indirect_pointer);
        3'h5: file_rd_data = pin_in.group[0] & GROUP_A_MASK;
        3'h6: file_rd_data = pin_in.group[1];
        3'h7: file_rd_data = HAS_PIN_GROUP_C ? pin_in.group[2] : data_mem[FILE_PIN_GROUP_C];
      endcase
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (rd_idx < IDX_PIN_DIRECTION_A) begin
      next_rdata = file_rd_data;
    end else if (rd_idx == IDX_CORE_CONTROL) begin
      next_rdata = core_control;
    end else if (rd_idx == IDX_POWER_STATE) begin
      next_rdata[STATE_SLEEP_BIT] = (power_state == PWR_SLEEP);
    end
  end

  // ------------------------------------------------------------
  // bus write channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      awready  <= 1'b1;
      awaddr_q <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      aw_held  <= 1'b1;
      awready  <= 1'b0;
      awaddr_q <= awaddr;
    end else if (wr_cycle) begin
      aw_held  <= 1'b0;
    end else if (bvalid && bready) begin
      awready  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wready  <= 1'b1;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wready  <= 1'b0;
      wdata_q <= wdata[7:0];
      wstrb_q <= wstrb[0];
    end else if (wr_cycle) begin
      w_held  <= 1'b0;
    end else if (bvalid && bready) begin
      wready  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_cycle) begin
      bvalid <= 1'b1;
      bresp  <= idx_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // bus read channel
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= idx_mapped(araddr) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
      rresp   <= idx_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// file: dv/crsw_checker.sv
`timescale 1ns/1ps
module crsw_checker
  import crsw_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        arvalid,
  input logic        arready,
  input logic        bvalid,
  input logic        bready,
  input logic        rvalid,
  input logic        instr_valid,
  input logic [11:0] instr_word,
  input logic        master_clear_pin_n,
  input logic        watchdog_timeout,
  input crsw_pins_s  pin_out,
  input crsw_pins_s  pin_oe,
  input logic [7:0]  program_counter_low,
  input logic        osc_enable,
  input logic        watchdog_clear,
  input logic        core_reset,
  input logic        powered_down
);
  // ----
  // helpers
  // ----
  logic run_ok;
  assign run_ok = osc_enable && !core_reset && instr_valid && master_clear_pin_n
                  && !watchdog_timeout;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_SLEEP_ENTRY: assert property (run_ok && instr_word == POWERDOWN_OPCODE
    |=> !osc_enable ##1 powered_down) else $error("sleep not entered");
  AST_SLEEP_CAUSE: assert property ($fell(osc_enable)
    |-> $past(run_ok && instr_word == POWERDOWN_OPCODE)) else $error("stray sleep");
  AST_SLEEP_HOLD: assert property (!osc_enable && !$past(osc_enable)
    |-> $stable(pin_out) && $stable(pin_oe) && $stable(program_counter_low))
    else $error("state moved in sleep");
  AST_MASTER_CLEAR_PIN_WAKE: assert property (!osc_enable && !master_clear_pin_n
    |=> osc_enable && core_reset && watchdog_clear) else $error("no clear wake");
  AST_WAKE_CLEAR: assert property ($rose(osc_enable) |-> watchdog_clear)
    else $error("wake without watchdog clear");
  AST_MASTER_CLEAR_PIN_RESET: assert property (!master_clear_pin_n |=> core_reset)
    else $error("clear pin did not reset");
  AST_PC_STEP: assert property (run_ok && instr_word == 12'h000
    |=> program_counter_low == $past(program_counter_low) + 8'h01)
    else $error("pc low did not step");
  AST_PD_LAG: assert property (powered_down == !osc_enable)
    else $error("powered_down mismatch");
  AST_WDCLR_CAUSE: assert property (watchdog_clear
    |-> osc_enable != $past(osc_enable)) else $error("stray watchdog clear");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("rvalid late");
endmodule

bind crsw_core_regs crsw_checker u_chk (
  .aclk, .aresetn, .arvalid, .arready, .bvalid, .bready, .rvalid,
  .instr_valid, .instr_word, .master_clear_pin_n, .watchdog_timeout,
  .pin_out, .pin_oe, .program_counter_low, .osc_enable, .watchdog_clear,
  .core_reset, .powered_down
);

// file: dv/crsw_core_model.sv
`timescale 1ns/1ps
module crsw_core_model
  import crsw_pkg::*;
(
  input  logic        osc_enable,
  input  logic        core_reset,
  input  logic        go_sleep,
  input  logic        hold_clear,
  input  logic        wdt_fire,
  output logic        instr_valid,
  output logic [11:0] instr_word,
  output logic        master_clear_pin_n,
  output logic        watchdog_timeout
);
  // ----
  // core and reset sources
  // ----
  assign instr_valid        = osc_enable && !core_reset;
  assign instr_word         = go_sleep ? POWERDOWN_OPCODE : 12'h000;
  assign master_clear_pin_n = !hold_clear;
  assign watchdog_timeout   = wdt_fire;
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import crsw_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, instr_valid;
  logic        master_clear_pin_n, watchdog_timeout, osc_enable, watchdog_clear;
  logic        core_reset, powered_down, go_sleep, hold_clear, wdt_fire;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [11:0] instr_word;
  logic        tick;
  logic [3:0]  strb;
  logic [7:0]  program_counter_low;
  crsw_pins_s  pin_in, pin_out, pin_oe;
  int          fails, total_checks, cyc, wdc_n, n;

  // undriven pins pulled up
  assign pin_in = crsw_pins_s'((pin_out & pin_oe) | ~pin_oe);

  crsw_core_regs #(.SMALL_MEMORY(1'b1), .HAS_PIN_GROUP_C(1'b0)) dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(strb), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .instr_valid, .instr_word, .timer_tick(tick), .master_clear_pin_n,
    .watchdog_timeout, .pin_in, .pin_out, .pin_oe, .program_counter_low,
    .osc_enable, .watchdog_clear, .core_reset, .powered_down);

  crsw_core_model core (.osc_enable, .core_reset, .go_sleep, .hold_clear,
    .wdt_fire, .instr_valid, .instr_word, .master_clear_pin_n, .watchdog_timeout);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && watchdog_clear === 1'b1) wdc_n <= wdc_n + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ----
  // helpers
  // ----
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge aclk);
    awaddr  <= {22'h0, idx, 2'h0};
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr  <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    rd(idx);
    check(nm, d, e);
  endtask

  task automatic sleep_now();
    @(posedge aclk);
    go_sleep <= 1'b1;
    @(posedge aclk);
    go_sleep <= 1'b0;
    while (powered_down !== 1'b1) @(posedge aclk);
    @(posedge aclk);
  endtask

  task automatic wake_wait();
    while (osc_enable !== 1'b1 || core_reset !== 1'b0) @(posedge aclk);
    @(posedge aclk);
  endtask

  task automatic master_clear_pin();
    @(posedge aclk);
    hold_clear <= 1'b1;
    repeat (2) @(posedge aclk);
    hold_clear <= 1'b0;
    wake_wait();
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    rchk("flags", 8'h03, 32'h18);
    rchk("group_a", 8'h05, 32'h0F);
    $display("reset values done");
  endtask

  task automatic t_map();
    wr(8'h04, 8'h07);
    wr(8'h00, 8'h5A);
    rchk("file7", 8'h07, 32'h5A);
    rchk("indirect_rd", 8'h00, 32'h5A);
    rchk("pointer", 8'h04, 32'hE7);
    wr(8'h0E, 8'h11);
    check("bresp_unmapped", r, RESP_SLVERR);
    rd(8'h0E);
    check("rresp_unmapped", r, RESP_SLVERR);
    $display("register map done");
  endtask

  task automatic t_tick_strb();
    wr(8'h01, 8'h10);
    @(posedge aclk);
    tick <= 1'b1;
    repeat (3) @(posedge aclk);
    tick <= 1'b0;
    rchk("timer_tick", 8'h01, 32'h13);
    strb <= 4'h0;
    wr(8'h01, 8'hAA);
    strb <= 4'hF;
    rchk("timer_no_strb", 8'h01, 32'h13);
    $display("timer and strobe done");
  endtask

  task automatic t_sleep_master_clear_pin();
    wr(8'h09, 8'h0F);
    wr(8'h06, 8'hA5);
    wr(8'h01, 8'h3C);
    n = wdc_n;
    sleep_now();
    check("osc", osc_enable, 32'h0);
    rchk("flags_sleep", 8'h03, 32'h10);
    rchk("power_state", 8'h0D, 32'h1);
    wr(8'h04, 8'h01);
    check("oe_b", pin_oe.group[1], 32'hF0);
    check("out_b", pin_out.group[1], 32'hA5);
    check("entry_clear", wdc_n, n);
    master_clear_pin();
    check("wake_clear", wdc_n, n + 1);
    check("oe_b_wake", pin_oe.group[1], 32'h0);
    rchk("flags_wake", 8'h03, 32'h10);
    rchk("timer", 8'h01, 32'h3C);
    rchk("pointer_kept", 8'h04, 32'hE7);
    $display("sleep and clear-pin wake done");
  endtask

  task automatic t_sleep_wdt();
    wr(8'h0C, 8'h01);
    n = wdc_n;
    sleep_now();
    check("entry_clear_wd", wdc_n, n + 1);
    @(posedge aclk);
    wdt_fire <= 1'b1;
    @(posedge aclk);
    wdt_fire <= 1'b0;
    wake_wait();
    check("wd_wake_clear", wdc_n, n + 2);
    rchk("flags_wd", 8'h03, 32'h00);
    wr(8'h0C, 8'h00);
    sleep_now();
    @(posedge aclk);
    wdt_fire <= 1'b1;
    @(posedge aclk);
    wdt_fire <= 1'b0;
    repeat (4) @(posedge aclk);
    check("wd_disabled", osc_enable, 32'h0);
    master_clear_pin();
    $display("watchdog wake done");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {go_sleep, hold_clear, wdt_fire} = '0;
    tick = 1'b0;
    strb = 4'hF;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    wdc_n = 0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1 check("pcl_reset", program_counter_low, PCL_RESET);
    t_reset();
    t_map();
    t_tick_strb();
    t_sleep_master_clear_pin();
    t_sleep_wdt();
    results();
  end
endmodule
